// ===== pkg/fpd_defines.svh
// fan pwm decoder: offsets-free timing counts, thresholds and widths
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH

// ****************************************************************
// clock
// ****************************************************************
`define FPD_CLK_KHZ 100000

// ****************************************************************
// command line timing
// ****************************************************************
`define FPD_FREQ_MIN_HZ 20
`define FPD_FREQ_MAX_HZ 150
`define FPD_PERIOD_MAX_CYC ((`FPD_CLK_KHZ * 1000) / `FPD_FREQ_MIN_HZ)
`define FPD_PERIOD_MIN_CYC ((`FPD_CLK_KHZ * 1000) / `FPD_FREQ_MAX_HZ)
`define FPD_LINE_TIMEOUT_US 55000
`define FPD_LINE_TIMEOUT_CYC ((`FPD_LINE_TIMEOUT_US * (`FPD_CLK_KHZ / 1000)))
`define FPD_MEAS_CNT_W 23

// ****************************************************************
// duty cycle
// ****************************************************************
`define FPD_DUTY_W 7
`define FPD_DUTY_STEP_SIZE 1
`define FPD_DUTY_FULL 100
`define FPD_DUTY_ZERO 0
`define FPD_BAND_LO 5
`define FPD_BAND_HI 95

// ****************************************************************
// plausibility
// ****************************************************************
`define FPD_PLAUS_MS 200
`define FPD_PLAUS_CYC (`FPD_PLAUS_MS * `FPD_CLK_KHZ)
`define FPD_PLAUS_COUNT 3

// ****************************************************************
// fallback and retry
// ****************************************************************
`define FPD_FALLBACK_MS 8000
`define FPD_FALLBACK_CYC (`FPD_FALLBACK_MS * `FPD_CLK_KHZ)
`define FPD_RETRY_STEP_MS 5000
`define FPD_RETRY_STEP_CYC (`FPD_RETRY_STEP_MS * `FPD_CLK_KHZ)
`define FPD_RETRY_MAX_STEPS 5
`define FPD_TIMER_W 32

// ****************************************************************
// speed request, percent of maximum speed
// ****************************************************************
`define FPD_SPEED_W 7
`define FPD_SPEED_MIN 25
`define FPD_SPEED_MAX 100
`define FPD_SPEED_DUTY_BASE 6
`define FPD_SPEED_SLOPE 873
`define FPD_SPEED_SHIFT 10

`endif

// ===== pkg/fpd_pkg.sv
// fan pwm decoder: shared types
package fpd_pkg;

  // ****************************************************************
  // modes, gray along active -> run -> failure
  // ****************************************************************
  typedef enum logic [1:0] {
    FPD_MODE_ACTIVE = 2'h0,
    FPD_MODE_RUN = 2'h1,
    FPD_MODE_FAIL = 2'h3
  } fpd_mode_t;

  typedef enum logic [1:0] {
    FPD_FAIL_NONE = 2'h0,
    FPD_FAIL_LOCKED = 2'h1,
    FPD_FAIL_SELF = 2'h2,
    FPD_FAIL_SUPPLY = 2'h3
  } fpd_fail_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic vld;
    logic [6:0] duty;
  } fpd_meas_t;

  typedef struct packed {
    logic self_check_fault;
    logic supply_voltage_fault;
    logic rotor_locked;
  } fpd_motor_stat_t;

endpackage

// ===== rtl/fpd_duty_meter.sv
// fan pwm decoder: period and high-time measurement, duty in percent
`timescale 1ns/1ps
`include "fpd_defines.svh"
module fpd_duty_meter #(
  parameter int CNT_W = `FPD_MEAS_CNT_W,
  parameter int TIMEOUT_CYC = `FPD_LINE_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_line,
  output fpd_pkg::fpd_meas_t o_meas
);
  import fpd_pkg::*;

  localparam int NUM_W = CNT_W + 7;

  if (TIMEOUT_CYC >= (2 ** CNT_W) || TIMEOUT_CYC < 2) begin : g_bad_cnt
    $error("fpd_duty_meter: timeout does not fit counter");
  end

  logic line_q_r;
  logic [CNT_W-1:0] per_r;
  logic [CNT_W-1:0] hi_r;
  logic busy_r;
  logic [2:0] bit_r;
  logic [NUM_W-1:0] num_r;
  logic [NUM_W-1:0] den_r;
  logic [6:0] quo_r;
  logic rise;
  logic tmo;
  logic [NUM_W-1:0] shifted;

  assign rise = i_line & ~line_q_r;
  assign tmo = (per_r == CNT_W'(TIMEOUT_CYC - 1));
  assign shifted = den_r << bit_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      line_q_r <= 1'b0;
    end else begin
      line_q_r <= i_line;
    end
  end

  // period from rising edge to rising edge, high time inside it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || rise || tmo) begin
      per_r <= '0;
      hi_r <= '0;
    end else begin
      per_r <= per_r + CNT_W'(1);
      hi_r <= hi_r + CNT_W'(i_line);
    end
  end

  // restoring division high*100/period, one quotient bit per cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      bit_r <= 3'h0;
      num_r <= '0;
      den_r <= '0;
      quo_r <= 7'h00;
      o_meas <= '0;
    end else begin
      o_meas.vld <= 1'b0;
      if (tmo) begin
        // no edge for longer than the slowest period: steady level
        busy_r <= 1'b0;
        o_meas.vld <= 1'b1;
        o_meas.duty <= i_line ? 7'(`FPD_DUTY_FULL) : 7'(`FPD_DUTY_ZERO);
      end else if (rise && per_r != '0) begin
        // every period up to the timeout is measured, 20 Hz..150 Hz and beyond
        busy_r <= 1'b1;
        bit_r <= 3'h6;
        num_r <= NUM_W'(hi_r) * NUM_W'(`FPD_DUTY_FULL);
        den_r <= NUM_W'(per_r) + NUM_W'(1);
        quo_r <= 7'h00;
      end else if (busy_r) begin
        if (num_r >= shifted) begin
          num_r <= num_r - shifted;
          quo_r[bit_r] <= 1'b1;
        end
        if (bit_r == 3'h0) begin
          busy_r <= 1'b0;
          o_meas.vld <= 1'b1;
          o_meas.duty <= (num_r >= shifted) ? (quo_r | 7'h01) : quo_r;
        end else begin
          bit_r <= bit_r - 3'h1;
        end
      end
    end
  end

endmodule // fpd_duty_meter

// ===== rtl/fpd_plaus.sv
// fan pwm decoder: consecutive-equal plausibility filter
`timescale 1ns/1ps
`include "fpd_defines.svh"
module fpd_plaus #(
  parameter int COUNT = `FPD_PLAUS_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input fpd_pkg::fpd_meas_t i_meas,
  output fpd_pkg::fpd_meas_t o_meas
);
  import fpd_pkg::*;

  if (COUNT < 2 || COUNT > 15) begin : g_bad_count
    $error("fpd_plaus: COUNT out of range");
  end

  logic [6:0] last_r;
  logic [3:0] cnt_r;

  // a value counts only after COUNT equal measurements in a row
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      last_r <= 7'h00;
      cnt_r <= 4'h0;
      o_meas <= '0;
    end else if (i_meas.vld) begin
      if (i_meas.duty != last_r || cnt_r == 4'h0) begin
        last_r <= i_meas.duty;
        cnt_r <= 4'h1;
      end else if (cnt_r != 4'(COUNT)) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'(COUNT - 1)) begin
          o_meas.vld <= 1'b1;
          o_meas.duty <= last_r;
        end
      end
    end
  end

endmodule // fpd_plaus

// ===== rtl/fpd_top.sv
// fan pwm decoder: speed command decode, drive modes and failure handling
//
// Behaviour
// - measure command repetition from 20 to 150 Hz
// - accept duty values from 0 to 100 percent
// - steady low is 0, steady high 100
// - duty in outer bands: full speed after 8 s
// - use duty only after consecutive equal measurements
// - plausibility delay stays at or below 0.2 s
// - three modes; electronics always active while powered
// - never enter a low-power quiescent mode
// - steady high line places drive in run
// - power-up with no pulses proceeds into run
// - run speed follows the validated duty cycle
// - on failure enter failure mode, stop motor
// - recover from failures on valid run command
// - startup self-check fault stops the drive
// - supply voltage out of range stops drive
`timescale 1ns/1ps
`include "fpd_defines.svh"
module fpd_top #(
  parameter int LINE_TIMEOUT_CYC = `FPD_LINE_TIMEOUT_CYC,
  parameter int PLAUS_COUNT = `FPD_PLAUS_COUNT,
  parameter int FALLBACK_CYC = `FPD_FALLBACK_CYC,
  parameter int RETRY_STEP_CYC = `FPD_RETRY_STEP_CYC
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // command line, level after the input stage
  input wire logic I_CMD_LINE,
  // motor and supervisor status
  input fpd_pkg::fpd_motor_stat_t I_MOTOR_STAT,
  // motor command
  output logic O_MOTOR_EN,
  output logic [6:0] O_SPEED_REQ,
  // status
  output fpd_pkg::fpd_mode_t O_MODE,
  output fpd_pkg::fpd_fail_t O_FAIL_CAUSE,
  output logic O_ELECTRONICS_ACTIVE,
  output fpd_pkg::fpd_meas_t O_DUTY,
  output logic O_FALLBACK_FULL,
  output logic O_RETRY_WAIT
);
  import fpd_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the plausibility chain must settle within its latency budget
  if (PLAUS_COUNT * LINE_TIMEOUT_CYC > `FPD_PLAUS_CYC) begin : g_bad_plaus
    $error("fpd_top: plausibility latency exceeds budget");
  end
  if (LINE_TIMEOUT_CYC < 2) begin : g_bad_tmo
    $error("fpd_top: line timeout too short");
  end
  if (FALLBACK_CYC < 2 || RETRY_STEP_CYC < 2) begin : g_bad_timer
    $error("fpd_top: timer counts too short");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  // outer band covers shorted and broken lines
  function automatic logic out_of_band(input logic [6:0] d);
    out_of_band = (d <= 7'(`FPD_BAND_LO)) || (d >= 7'(`FPD_BAND_HI));
  endfunction

  // monotonic line from minimum to maximum speed
  function automatic logic [6:0] map_speed(input logic [6:0] d);
    logic [6:0] off;
    logic [16:0] prod;
    off = 7'h00;
    prod = 17'h00000;
    off = d - 7'(`FPD_SPEED_DUTY_BASE);
    prod = 17'(off) * 17'(`FPD_SPEED_SLOPE);
    map_speed = 7'(prod >> `FPD_SPEED_SHIFT) + 7'(`FPD_SPEED_MIN);
  endfunction

  // ****************************************************************
  // measurement chain
  // ****************************************************************
  fpd_meas_t raw_meas;
  fpd_meas_t duty_ok;

  // line is sampled as is; the host's wake pulse (>= 150 us) is far
  // longer than a clock, so no extra filter is needed
  // low is the host's switch to ground, high the pull-up
  fpd_duty_meter #(
    .CNT_W(`FPD_MEAS_CNT_W),
    .TIMEOUT_CYC(LINE_TIMEOUT_CYC)
  ) u_meter (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_line(I_CMD_LINE),
    .o_meas(raw_meas)
  );

  fpd_plaus #(
    .COUNT(PLAUS_COUNT)
  ) u_plaus (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_meas(raw_meas),
    .o_meas(duty_ok)
  );

  // ****************************************************************
  // fallback timer
  // ****************************************************************
  logic [`FPD_TIMER_W-1:0] fb_cnt_r;
  logic fb_full_r;
  logic oob;

  assign oob = duty_ok.vld && out_of_band(duty_ok.duty);

  // the count parks at its end value, so full speed holds while out of band
  // counts while out of band, cleared by a valid in-band duty
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || !oob) begin
      fb_cnt_r <= '0;
      fb_full_r <= 1'b0;
    end else if (fb_cnt_r == `FPD_TIMER_W'(FALLBACK_CYC - 1)) begin
      fb_full_r <= 1'b1;
    end else begin
      fb_cnt_r <= fb_cnt_r + `FPD_TIMER_W'(1);
    end
  end

  // ****************************************************************
  // speed target
  // ****************************************************************
  logic [6:0] speed_tgt;
  logic run_cmd;

  // whole 0..100 span is decoded, nothing is rejected
  always_comb begin
    speed_tgt = 7'h00;
    if (!duty_ok.vld) begin
      speed_tgt = 7'h00;
    end else if (oob) begin
      speed_tgt = fb_full_r ? 7'(`FPD_SPEED_MAX) : 7'h00;
    end else begin
      speed_tgt = map_speed(duty_ok.duty);
    end
  end

  assign run_cmd = (speed_tgt != 7'h00);

  // ****************************************************************
  // retry timing for a locked rotor
  // ****************************************************************
  fpd_mode_t mode_r;
  fpd_mode_t mode_nxt;
  fpd_fail_t cause_r;
  fpd_fail_t cause_nxt;
  logic [2:0] attempts_r;
  logic [2:0] steps_r;
  logic [`FPD_TIMER_W-1:0] step_cnt_r;
  logic wait_done;
  logic lock_evt;
  logic fault_self;
  logic fault_supply;

  assign fault_self = I_MOTOR_STAT.self_check_fault;
  assign fault_supply = I_MOTOR_STAT.supply_voltage_fault;
  assign lock_evt = (mode_r == FPD_MODE_RUN) && O_MOTOR_EN && I_MOTOR_STAT.rotor_locked;
  assign wait_done = (steps_r >= attempts_r);

  // attempts survive a retry and clear only when the run command goes
  // each failed start adds one 5 s step, held at five steps
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      attempts_r <= 3'h0;
    end else if (lock_evt) begin
      if (attempts_r != 3'(`FPD_RETRY_MAX_STEPS)) begin
        attempts_r <= attempts_r + 3'h1;
      end
    end else if (!run_cmd) begin
      attempts_r <= 3'h0;
    end
  end

  // step timer runs only while waiting in failure on a locked rotor
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || mode_r != FPD_MODE_FAIL || cause_r != FPD_FAIL_LOCKED) begin
      step_cnt_r <= '0;
      steps_r <= 3'h0;
    end else if (!wait_done) begin
      if (step_cnt_r == `FPD_TIMER_W'(RETRY_STEP_CYC - 1)) begin
        step_cnt_r <= '0;
        steps_r <= steps_r + 3'h1;
      end else begin
        step_cnt_r <= step_cnt_r + `FPD_TIMER_W'(1);
      end
    end
  end

  // ****************************************************************
  // mode machine
  // ****************************************************************
  // there is no quiescent state to reach, on purpose
  always_comb begin
    mode_nxt = mode_r;
    cause_nxt = cause_r;
    case (mode_r)
      FPD_MODE_ACTIVE: begin
        if (fault_self) begin
          mode_nxt = FPD_MODE_FAIL;
          cause_nxt = FPD_FAIL_SELF;
        end else if (fault_supply) begin
          mode_nxt = FPD_MODE_FAIL;
          cause_nxt = FPD_FAIL_SUPPLY;
        end else if (duty_ok.vld) begin
          // steady high yields a valid 100 and so run
          mode_nxt = FPD_MODE_RUN;
        end
      end
      FPD_MODE_RUN: begin
        if (fault_self) begin
          mode_nxt = FPD_MODE_FAIL;
          cause_nxt = FPD_FAIL_SELF;
        end else if (fault_supply) begin
          mode_nxt = FPD_MODE_FAIL;
          cause_nxt = FPD_FAIL_SUPPLY;
        end else if (lock_evt) begin
          mode_nxt = FPD_MODE_FAIL;
          cause_nxt = FPD_FAIL_LOCKED;
        end
      end
      FPD_MODE_FAIL: begin
        // a fault that is still present keeps failure and names its cause,
        // the self-check fault winning over the supply fault
        if (fault_self) begin
          cause_nxt = FPD_FAIL_SELF;
        end else if (fault_supply) begin
          cause_nxt = FPD_FAIL_SUPPLY;
        end else if (run_cmd && (cause_r != FPD_FAIL_LOCKED || wait_done)) begin
          // retry only on a valid command asking to run
          mode_nxt = FPD_MODE_RUN;
          cause_nxt = FPD_FAIL_NONE;
        end
      end
      default: begin
        mode_nxt = FPD_MODE_ACTIVE;
        cause_nxt = FPD_FAIL_NONE;
      end
    endcase
  end

  // three modes only: active, run and failure
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mode_r <= FPD_MODE_ACTIVE;
      cause_r <= FPD_FAIL_NONE;
    end else begin
      mode_r <= mode_nxt;
      cause_r <= cause_nxt;
    end
  end

  // ****************************************************************
  // motor command
  // ****************************************************************
  // stopped in every mode but run; failure stops at once
  // taken from the next mode, so the motor drops on the edge that
  // enters failure and never runs a cycle inside it
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_MOTOR_EN <= 1'b0;
      O_SPEED_REQ <= 7'h00;
    end else if (mode_nxt == FPD_MODE_RUN && run_cmd) begin
      O_MOTOR_EN <= 1'b1;
      O_SPEED_REQ <= speed_tgt;
    end else begin
      O_MOTOR_EN <= 1'b0;
      O_SPEED_REQ <= 7'h00;
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_DUTY <= '0;
      O_FALLBACK_FULL <= 1'b0;
      O_RETRY_WAIT <= 1'b0;
      O_ELECTRONICS_ACTIVE <= 1'b1;
    end else begin
      O_DUTY <= duty_ok;
      O_FALLBACK_FULL <= fb_full_r;
      O_RETRY_WAIT <= (mode_r == FPD_MODE_FAIL) && (cause_r == FPD_FAIL_LOCKED) && !wait_done;
      O_ELECTRONICS_ACTIVE <= 1'b1;
    end
  end

  assign O_MODE = mode_r;
  assign O_FAIL_CAUSE = cause_r;

endmodule // fpd_top

// ===== tb/fpd_host_model.sv
// fan pwm decoder: host controller model, open-collector pwm source
`timescale 1ns/1ps
module fpd_host_model (
  // clock
  input wire logic i_clk,
  // pwm shape: period 0 means steady, high 0 then pulls low
  input wire logic [15:0] i_period,
  input wire logic [15:0] i_high,
  // line level seen by the drive
  output logic o_line
);
  logic [15:0] cnt_r = 16'h0;
  logic pull_low_r = 1'b0;
  always_ff @(posedge i_clk) begin
    cnt_r <= (i_period == 16'h0 || cnt_r + 16'h1 >= i_period) ? 16'h0 : cnt_r + 16'h1;
    pull_low_r <= (i_period == 16'h0) ? (i_high == 16'h0) : (cnt_r >= i_high);
  end
  // each level lasts whole programmed counts, so a wake pulse is never
  // shorter than the programmed high time
  // host only sinks; released line rises through the pull-up
  assign o_line = pull_low_r ? 1'b0 : 1'b1;
endmodule // fpd_host_model

// ===== tb/fpd_top_sva.sv
// fan pwm decoder: port-level assertions and bind
`timescale 1ns/1ps
module fpd_top_sva
  import fpd_pkg::*;
#(
  parameter int LINE_TIMEOUT_CYC = 5500000,
  parameter int PLAUS_COUNT = 3,
  parameter int FALLBACK_CYC = 800000000,
  parameter int RETRY_STEP_CYC = 500000000
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // inputs and outputs of the top
  input wire logic I_CMD_LINE,
  input fpd_pkg::fpd_motor_stat_t I_MOTOR_STAT,
  input wire logic O_MOTOR_EN,
  input wire logic [6:0] O_SPEED_REQ,
  input fpd_pkg::fpd_mode_t O_MODE,
  input fpd_pkg::fpd_fail_t O_FAIL_CAUSE,
  input wire logic O_ELECTRONICS_ACTIVE,
  input fpd_pkg::fpd_meas_t O_DUTY,
  input wire logic O_FALLBACK_FULL,
  input wire logic O_RETRY_WAIT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_elec_on; O_ELECTRONICS_ACTIVE; endproperty
  property p_no_quiet; O_MODE != 2'h2; endproperty
  property p_en_run; O_MOTOR_EN |-> O_MODE == FPD_MODE_RUN; endproperty
  property p_fail_stop; O_MODE == FPD_MODE_FAIL |-> !O_MOTOR_EN && O_SPEED_REQ == 7'h0; endproperty
  property p_spd_rng;
    O_MOTOR_EN ? (O_SPEED_REQ >= 7'h19 && O_SPEED_REQ <= 7'h64) : O_SPEED_REQ == 7'h0;
  endproperty
  property p_vld_keep; O_DUTY.vld |=> O_DUTY.vld; endproperty
  property p_supply;
    $rose(I_MOTOR_STAT.supply_voltage_fault) && !I_MOTOR_STAT.self_check_fault |->
      ##[1:2] (O_MODE == FPD_MODE_FAIL && O_FAIL_CAUSE == FPD_FAIL_SUPPLY);
  endproperty
  property p_self;
    $rose(I_MOTOR_STAT.self_check_fault) |->
      ##[1:2] (O_MODE == FPD_MODE_FAIL && O_FAIL_CAUSE == FPD_FAIL_SELF);
  endproperty
  property p_lock;
    O_MODE == FPD_MODE_RUN && O_MOTOR_EN && I_MOTOR_STAT == 3'h1 |->
      ##[1:2] (O_MODE == FPD_MODE_FAIL && O_FAIL_CAUSE == FPD_FAIL_LOCKED);
  endproperty
  // shortest retry step is far above eight cycles
  property p_lock_hold;
    $rose(O_MODE == FPD_MODE_FAIL && O_FAIL_CAUSE == FPD_FAIL_LOCKED) |=>
      (O_MODE == FPD_MODE_FAIL)[*8];
  endproperty
  property p_fb_clear;
    O_FALLBACK_FULL && O_DUTY.vld && O_DUTY.duty >= 7'h6 && O_DUTY.duty <= 7'h5E |->
      ##[1:2] !O_FALLBACK_FULL;
  endproperty
  // ****************************************************************
  // assertions and covers
  // ****************************************************************
  a_elec_on: assert property (p_elec_on) else $error("electronics not active");
  a_no_quiet: assert property (p_no_quiet) else $error("illegal mode");
  a_en_run: assert property (p_en_run) else $error("motor on outside run");
  a_fail_stop: assert property (p_fail_stop) else $error("motor on in failure");
  a_spd_rng: assert property (p_spd_rng) else $error("speed out of range");
  a_vld_keep: assert property (p_vld_keep) else $error("duty valid dropped");
  a_supply: assert property (p_supply) else $error("supply fault missed");
  a_self: assert property (p_self) else $error("self check fault missed");
  a_lock: assert property (p_lock) else $error("locked rotor missed");
  a_lock_hold: assert property (p_lock_hold) else $error("retry too early");
  a_fb_clear: assert property (p_fb_clear) else $error("fallback not cleared");
  c_run: cover property (O_MODE == FPD_MODE_RUN && O_MOTOR_EN);
  c_lock: cover property (O_RETRY_WAIT);
  c_fb: cover property (O_FALLBACK_FULL);
endmodule // fpd_top_sva

bind fpd_top fpd_top_sva #(
  .LINE_TIMEOUT_CYC(LINE_TIMEOUT_CYC),
  .PLAUS_COUNT(PLAUS_COUNT),
  .FALLBACK_CYC(FALLBACK_CYC),
  .RETRY_STEP_CYC(RETRY_STEP_CYC)
) u_sva (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CMD_LINE(I_CMD_LINE), .I_MOTOR_STAT(I_MOTOR_STAT),
  .O_MOTOR_EN(O_MOTOR_EN), .O_SPEED_REQ(O_SPEED_REQ), .O_MODE(O_MODE),
  .O_FAIL_CAUSE(O_FAIL_CAUSE), .O_ELECTRONICS_ACTIVE(O_ELECTRONICS_ACTIVE), .O_DUTY(O_DUTY),
  .O_FALLBACK_FULL(O_FALLBACK_FULL), .O_RETRY_WAIT(O_RETRY_WAIT)
);

// ===== tb/fpd_top_tb_top.sv
// fan pwm decoder: self-checking testbench
`timescale 1ns/1ps
module fpd_top_tb_top;
  import fpd_pkg::*;
  // scaled counts keep the run short
  localparam int TO = 300;
  localparam int FB = 1000;
  localparam int RS = 500;
  localparam int PER = 200;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  fpd_motor_stat_t I_MOTOR_STAT = '0;
  logic [15:0] per_r = 16'h0;
  logic [15:0] high_r = 16'h1;
  wire cmd_line;
  logic O_MOTOR_EN, O_ELECTRONICS_ACTIVE, O_FALLBACK_FULL, O_RETRY_WAIT;
  logic [6:0] O_SPEED_REQ;
  fpd_mode_t O_MODE;
  fpd_fail_t O_FAIL_CAUSE;
  fpd_meas_t O_DUTY;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  fpd_host_model host (.i_clk(I_CLK), .i_period(per_r), .i_high(high_r), .o_line(cmd_line));
  fpd_top #(.LINE_TIMEOUT_CYC(TO), .PLAUS_COUNT(3), .FALLBACK_CYC(FB), .RETRY_STEP_CYC(RS)) dut (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CMD_LINE(cmd_line), .I_MOTOR_STAT(I_MOTOR_STAT),
    .O_MOTOR_EN(O_MOTOR_EN), .O_SPEED_REQ(O_SPEED_REQ), .O_MODE(O_MODE),
    .O_FAIL_CAUSE(O_FAIL_CAUSE), .O_ELECTRONICS_ACTIVE(O_ELECTRONICS_ACTIVE), .O_DUTY(O_DUTY),
    .O_FALLBACK_FULL(O_FALLBACK_FULL), .O_RETRY_WAIT(O_RETRY_WAIT));
  initial forever #5 I_CLK = ~I_CLK;
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask
  function automatic int spd(input int d);
    return 25 + (((d - 6) * 873) >>> 10);
  endfunction
  // n counts the cycles spent waiting
  task automatic wait_mode(input fpd_mode_t m, input int max, output int n);
    n = 0;
    while (O_MODE !== m && n < max) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
  endtask
  task automatic wait_fb(input logic lvl, input int max, output int n);
    n = 0;
    while (O_FALLBACK_FULL !== lvl && n < max) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
  endtask
  task automatic set_pwm(input int p, input int h);
    @(posedge I_CLK);
    per_r <= p[15:0];
    high_r <= h[15:0];
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(O_MODE, FPD_MODE_ACTIVE);
    chk(O_ELECTRONICS_ACTIVE, 1'b1);
    chk({O_MOTOR_EN, O_SPEED_REQ, O_FALLBACK_FULL, O_RETRY_WAIT}, 0);
    chk(O_DUTY, 8'h0);
    $display("test reset done");
  endtask
  task automatic t_steady_high();
    int n;
    wait_mode(FPD_MODE_RUN, 4 * TO + 20, n);
    chk(O_MODE, FPD_MODE_RUN);
    chk(O_DUTY, {1'b1, 7'h64});
    chk(O_SPEED_REQ, 7'h0);
    wait_fb(1'b1, FB + 2 * TO, n);
    chk_rng(n, FB - 10, FB + 10);
    @(posedge I_CLK);
    #1;
    chk({O_MOTOR_EN, O_SPEED_REQ}, {1'b1, 7'h64});
    $display("test steady high done");
  endtask
  task automatic t_duty(input int h);
    fpd_meas_t old;
    int n;
    int d;
    d = h * 100 / PER;
    old = O_DUTY;
    set_pwm(PER, h);
    repeat (PER) @(posedge I_CLK);
    #1;
    chk(O_DUTY, old);
    n = 0;
    while (O_DUTY === old && n < 5 * PER) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    chk_rng(O_DUTY.duty, d - 1, d + 1);
    repeat (3) @(posedge I_CLK);
    #1;
    chk_rng(O_SPEED_REQ, spd(d - 1), spd(d + 1));
    chk({O_MOTOR_EN, O_FALLBACK_FULL}, 2'b10);
    $display("test duty %0d done", d);
  endtask
  task automatic t_low();
    int n;
    set_pwm(0, 0);
    n = 0;
    while (O_DUTY.duty !== 7'h0 && n < 5 * TO) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    repeat (3) @(posedge I_CLK);
    #1;
    chk({O_DUTY, O_MOTOR_EN, O_SPEED_REQ}, {1'b1, 7'h0, 1'b0, 7'h0});
    wait_fb(1'b1, FB + 20, n);
    @(posedge I_CLK);
    #1;
    chk({O_FALLBACK_FULL, O_SPEED_REQ}, {1'b1, 7'h64});
    $display("test low line done");
  endtask
  task automatic t_fault();
    int n;
    @(posedge I_CLK);
    I_MOTOR_STAT <= 3'h2;
    wait_mode(FPD_MODE_FAIL, 5, n);
    chk({O_FAIL_CAUSE, O_MOTOR_EN, O_SPEED_REQ}, {FPD_FAIL_SUPPLY, 8'h0});
    repeat (3) @(posedge I_CLK);
    I_MOTOR_STAT <= 3'h6;
    repeat (3) @(posedge I_CLK);
    #1;
    chk(O_FAIL_CAUSE, FPD_FAIL_SELF);
    @(posedge I_CLK);
    I_MOTOR_STAT <= 3'h0;
    wait_mode(FPD_MODE_RUN, 10, n);
    @(posedge I_CLK);
    #1;
    chk({O_MODE, O_MOTOR_EN}, {FPD_MODE_RUN, 1'b1});
    $display("test faults done");
  endtask
  task automatic t_locked(input int k);
    int n;
    @(posedge I_CLK);
    I_MOTOR_STAT <= 3'h1;
    wait_mode(FPD_MODE_FAIL, 5, n);
    @(posedge I_CLK);
    I_MOTOR_STAT <= 3'h0;
    #1;
    chk({O_MODE, O_FAIL_CAUSE, O_RETRY_WAIT}, {FPD_MODE_FAIL, FPD_FAIL_LOCKED, 1'b1});
    wait_mode(FPD_MODE_RUN, 3 * k * RS, n);
    chk_rng(n, k * RS - 10, k * RS + 10);
    $display("test locked rotor %0d done", k);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    #1;
    t_reset();
    t_steady_high();
    t_duty(100);
    t_duty(14);
    t_duty(180);
    t_low();
    t_duty(100);
    t_fault();
    t_locked(1);
    t_locked(2);
    test_done();
  end
endmodule // fpd_top_tb_top
